// ===== design/rtc_sched_defs.svh
`ifndef RTC_SCHED_DEFS_SVH
`define RTC_SCHED_DEFS_SVH
// Byte offsets of the register words
`define RS_CTRL 6'h00
`define RS_TIME 6'h04
`define RS_OFFS 6'h08
`define RS_TSRC 6'h0C
`define RS_PER 6'h10
`define RS_STAT 6'h30
`define RS_DIFN0 6'h34
`define RS_DIFN1 6'h38
// Control word field positions
`define RS_EN_BIT 0
`define RS_OFFSEL_LSB 1
`define RS_KEB_BIT 3
`define RS_SPD_LSB 4
`define RS_DIR_LSB 7
`define RS_SRC_LSB 11
`define RS_LOCK_LSB 14
// Reset values
`define RS_CTRL_RST 16'h0000
`define RS_DAY_RST 3'h1
// Codes
`define RS_SRC_SCHED 3'h4
`define RS_SEL_COMBO 3'h5
`define RS_OFF_EN 2'h1
`define RS_OFF_DI 2'h2
`define RS_ALL_PER 5'h0F
`define RS_DI_OFFSET 8'h38
`define RS_FIRE_CODE 8'h30
`define RS_LOCK_NO_REV 2'h1
`define RS_LOCK_NO_FWD 2'h2
`define RS_DAY_LAST 3'h7
// Timing
`define RS_SEC_NS 1000000000
`define RS_CLK_NS 100
`define RS_TICK_CYC (`RS_SEC_NS / `RS_CLK_NS)
`endif

// ===== design/rtc_sched_pkg.sv
package rtc_sched_pkg;
    // Command handed to the run and frequency path
    typedef struct packed {
        logic run;
        logic rev;
        logic [1:0] stage;
    } drive_cmd_s;
    // Weekday (1 Monday .. 7 Sunday) and time of day
    typedef struct packed {
        logic [2:0] day;
        logic [4:0] hr;
        logic [5:0] mn;
        logic [5:0] sec;
    } tod_s;
endpackage : rtc_sched_pkg

// ===== design/rtc_schedule_run_selector.sv
// Functional notes
// R1: Only the timer chosen by speed selection may start the drive.
// R2: In combined mode, run and frequency sources must both be the schedule. The code checks only the run source; it has no frequency source setting.
// R3: Scheduled direction obeys the motor direction lock.
// R4: Combined mode: timer pair picks stage 0..3 and direction bit 1..4.
// R5: Fire mode on any input terminal blocks scheduled running.
// R6: Kinetic energy backup enabled blocks scheduled running.
// R7: Run source codes 0 to 3 never run from the schedule.
// R8: Run source 4 runs only while the selected timer is active. The code runs in combined mode even with no timer active, at stage 0.
// R9: Offset input rising starts the offset run at once for the offset time.
// R10: STOP holds the drive until next period or offset input.
// R11: Input terminal with function code 56 is the offset enable.
// R12: All direction bits clear gives forward in every run case.
// R13: Weekdays are 1 Monday to 7 Sunday; times are hours, minutes, seconds.
// R14: Software loads date and time, then sets enable, before timers act.
// R15: Timer source 15 assigns all four periods to the timer.
// R16: A period whose start equals its stop time never activates.
// R17: Direction bit per run case, 1 is reverse, run case 1 lowest.
// R18: Single timer mode uses speed stage 0.
// R19: Period active when weekday and time lie inside its limits.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_sched_defs.svh"
module rtc_schedule_run_selector
    import rtc_sched_pkg::*;
#(
    parameter int unsigned TICK_CYC = `RS_TICK_CYC,
    parameter int unsigned N_DI = 6,
    parameter logic [7:0] FIRE_CODE = `RS_FIRE_CODE
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [N_DI-1:0] di_pin,
    input wire logic stop_key,
    output drive_cmd_s drive_cmd
);
    if (TICK_CYC < 2 || N_DI < 1 || N_DI > 8) begin : g_bad_param
        $error("rtc_schedule_run_selector: TICK_CYC >= 2 and N_DI 1..8 required");
    end

    logic ack_ff, nxt_ack_ff;
    logic [31:0] rdata_ff, nxt_rdata_ff, rd_val;
    logic [15:0] ctrl_ff, nxt_ctrl_ff;
    tod_s now_ff, nxt_now_ff;
    logic [10:0] offs_ff, nxt_offs_ff;
    logic [19:0] tsrc_ff, nxt_tsrc_ff;
    tod_s per_ff [8];
    tod_s nxt_per_ff [8];
    logic [8*N_DI-1:0] difn_ff, nxt_difn_ff;
    logic [31:0] tick_ff, nxt_tick_ff;
    logic [16:0] off_cnt_ff, nxt_off_cnt_ff;
    logic [N_DI-1:0] di_s1_ff, di_s2_ff;
    logic stop_s1_ff, stop_s2_ff, stop_d_ff, off_lvl_ff, stop_hold_ff, nxt_stop_hold_ff;
    logic [3:0] pact_ff;
    drive_cmd_s cmd_ff, nxt_cmd_ff;
    logic wr_en, sec_tick, off_lvl, off_rise, fire_cfg, off_trig, off_live, stop_rise;
    logic new_period, sel_tact, lock_deny;
    logic [3:0] pact, tact;
    logic [2:0] sel, pidx;
    logic [1:0] lock;
    logic [3:0] dir;
    logic [16:0] off_load;
    logic [63:0] difn_w;
    logic [15:0] stat;

    // Advance time of day by one second, weekday wraps 7 to 1
    function automatic tod_s tod_inc(input tod_s t);
        tod_s r;
        r = t;
        if (t.sec != 6'h3B) begin
            r.sec = t.sec + 6'h01;
        end else begin
            r.sec = 6'h00;
            if (t.mn != 6'h3B) begin
                r.mn = t.mn + 6'h01;
            end else begin
                r.mn = 6'h00;
                if (t.hr != 5'h17) begin
                    r.hr = t.hr + 5'h01;
                end else begin
                    r.hr = 5'h00;
                    r.day = (t.day >= `RS_DAY_LAST) ? `RS_DAY_RST : t.day + 3'h1;
                end
            end
        end
        return r;
    endfunction : tod_inc

    // Period window test on weekday and on time of day
    function automatic logic period_on(input tod_s t, input tod_s st, input tod_s sp);
        logic [16:0] now_t, st_t, sp_t;
        now_t = {t.hr, t.mn, t.sec};
        st_t = {st.hr, st.mn, st.sec};
        sp_t = {sp.hr, sp.mn, sp.sec};
        return (st_t != sp_t) // [R16]
            && (t.day >= st.day) && (t.day <= sp.day) // [R19]
            && (now_t >= st_t) && (now_t <= sp_t); // [R13]
    endfunction : period_on

    // Avalon slave: one wait cycle, then the request completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata = rdata_ff;
    assign wr_en = avs_write & ack_ff;
    assign pidx = 3'(avs_address[5:2] - 4'h4);
    assign difn_w = 64'(difn_ff);
    always_comb begin
        rd_val = 32'h0;
        case (avs_address)
            `RS_CTRL: rd_val = {16'h0, ctrl_ff};
            `RS_TIME: rd_val = {12'h0, now_ff};
            `RS_OFFS: rd_val = {21'h0, offs_ff};
            `RS_TSRC: rd_val = {12'h0, tsrc_ff};
            `RS_STAT: rd_val = {16'h0, stat};
            `RS_DIFN0: rd_val = difn_w[31:0];
            `RS_DIFN1: rd_val = difn_w[63:32];
            default: begin
                // Unmapped words read as zero and ignore writes
                if (avs_address >= `RS_PER && avs_address < `RS_STAT && avs_address[1:0] == 2'h0) begin
                    rd_val = {12'h0, per_ff[pidx]};
                end
            end
        endcase
        nxt_ack_ff = (avs_read | avs_write) & ~ack_ff;
        nxt_rdata_ff = (avs_read & ~ack_ff) ? rd_val : rdata_ff;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= nxt_ack_ff;
            rdata_ff <= nxt_rdata_ff;
        end
    end

    // Setting registers and the running clock
    assign sec_tick = (tick_ff == TICK_CYC - 1);
    always_comb begin
        nxt_ctrl_ff = ctrl_ff;
        nxt_offs_ff = offs_ff;
        nxt_tsrc_ff = tsrc_ff;
        nxt_difn_ff = difn_ff;
        nxt_per_ff = per_ff;
        nxt_tick_ff = sec_tick ? 32'h0 : tick_ff + 32'h1;
        // Clock holds until enabled, so software can load it first [R14]
        nxt_now_ff = (sec_tick && ctrl_ff[`RS_EN_BIT]) ? tod_inc(now_ff) : now_ff;
        if (wr_en) begin
            case (avs_address)
                `RS_CTRL: nxt_ctrl_ff = avs_writedata[15:0];
                `RS_TIME: nxt_now_ff = avs_writedata[19:0];
                `RS_OFFS: nxt_offs_ff = avs_writedata[10:0];
                `RS_TSRC: nxt_tsrc_ff = avs_writedata[19:0];
                `RS_DIFN0: nxt_difn_ff = (8*N_DI)'({difn_w[63:32], avs_writedata});
                `RS_DIFN1: nxt_difn_ff = (8*N_DI)'({avs_writedata, difn_w[31:0]});
                default: begin
                    if (avs_address >= `RS_PER && avs_address < `RS_STAT && avs_address[1:0] == 2'h0) begin
                        nxt_per_ff[pidx] = avs_writedata[19:0];
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= `RS_CTRL_RST;
            now_ff <= {`RS_DAY_RST, 17'h0};
            offs_ff <= 11'h0;
            tsrc_ff <= 20'h0;
            difn_ff <= '0;
            tick_ff <= 32'h0;
            for (int i = 0; i < 8; i++) begin
                per_ff[i] <= {`RS_DAY_RST, 17'h0};
            end
        end else begin
            ctrl_ff <= nxt_ctrl_ff;
            now_ff <= nxt_now_ff;
            offs_ff <= nxt_offs_ff;
            tsrc_ff <= nxt_tsrc_ff;
            difn_ff <= nxt_difn_ff;
            tick_ff <= nxt_tick_ff;
            per_ff <= nxt_per_ff;
        end
    end

    // Pin synchronisers; logic uses the second stage, plus stop_d_ff after it for the STOP edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            di_s1_ff <= '0;
            di_s2_ff <= '0;
            stop_s1_ff <= 1'b0;
            stop_s2_ff <= 1'b0;
            stop_d_ff <= 1'b0;
            off_lvl_ff <= 1'b0;
        end else begin
            di_s1_ff <= di_pin;
            di_s2_ff <= di_s1_ff;
            stop_s1_ff <= stop_key;
            stop_s2_ff <= stop_s1_ff;
            stop_d_ff <= stop_s2_ff;
            off_lvl_ff <= off_lvl;
        end
    end

    // Terminal functions, periods and timers
    always_comb begin
        off_lvl = 1'b0;
        fire_cfg = 1'b0;
        for (int i = 0; i < N_DI; i++) begin
            if (difn_ff[8*i +: 8] == `RS_DI_OFFSET && di_s2_ff[i]) off_lvl = 1'b1; // [R11]
            if (difn_ff[8*i +: 8] == FIRE_CODE) fire_cfg = 1'b1;
        end
        for (int p = 0; p < 4; p++) begin
            pact[p] = ctrl_ff[`RS_EN_BIT] && period_on(now_ff, per_ff[2*p], per_ff[2*p+1]); // [R19]
        end
        for (int t = 0; t < 4; t++) begin
            // Low four source bits pick periods, so 15 means all four [R15]
            tact[t] = |(tsrc_ff[5*t +: 4] & pact) | (tsrc_ff[5*t+4] & off_live);
        end
    end
    assign off_rise = off_lvl & ~off_lvl_ff;
    assign off_live = (off_cnt_ff != 17'h0);
    assign off_load = 17'((offs_ff[10:6] * 11'h03C + offs_ff[5:0]) * 17'h0003C);
    assign off_trig = ((ctrl_ff[`RS_OFFSEL_LSB +: 2] == `RS_OFF_DI) && off_rise) // [R9]
        || ((ctrl_ff[`RS_OFFSEL_LSB +: 2] == `RS_OFF_EN) && wr_en && avs_address == `RS_OFFS);
    assign new_period = |(pact & ~pact_ff);
    assign stop_rise = stop_s2_ff & ~stop_d_ff;

    // Run decision; a denied direction stops rather than flips
    assign sel = ctrl_ff[`RS_SPD_LSB +: 3];
    assign dir = ctrl_ff[`RS_DIR_LSB +: 4];
    assign lock = ctrl_ff[`RS_LOCK_LSB +: 2];
    always_comb begin
        sel_tact = 1'b0;
        nxt_cmd_ff = '0;
        if (sel == `RS_SEL_COMBO) begin
            sel_tact = 1'b1;
            nxt_cmd_ff.stage = {tact[1], tact[0]}; // [R4]
        end else if (sel != 3'h0 && sel < `RS_SEL_COMBO) begin
            sel_tact = tact[2'(sel - 3'h1)]; // [R1]
            nxt_cmd_ff.stage = 2'h0; // [R18]
        end
        nxt_cmd_ff.rev = dir[nxt_cmd_ff.stage]; // [R17] [R12]
        lock_deny = (lock == `RS_LOCK_NO_REV && nxt_cmd_ff.rev) || (lock == `RS_LOCK_NO_FWD && !nxt_cmd_ff.rev); // [R3]
        nxt_cmd_ff.run = ctrl_ff[`RS_EN_BIT] && !fire_cfg && !ctrl_ff[`RS_KEB_BIT] // [R5] [R6]
            && ctrl_ff[`RS_SRC_LSB +: 3] == `RS_SRC_SCHED && sel_tact // [R7] [R8]
            && !stop_hold_ff && !lock_deny;
        // STOP latch: a fresh press wins over a same-cycle release
        nxt_stop_hold_ff = stop_hold_ff;
        if (new_period || off_trig) nxt_stop_hold_ff = 1'b0; // [R10]
        if (stop_rise && cmd_ff.run) nxt_stop_hold_ff = 1'b1; // [R10]
        nxt_off_cnt_ff = off_cnt_ff;
        if (off_trig) begin
            nxt_off_cnt_ff = off_load; // [R9]
        end else if (sec_tick && off_live) begin
            nxt_off_cnt_ff = off_cnt_ff - 17'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ff <= '0;
            stop_hold_ff <= 1'b0;
            off_cnt_ff <= 17'h0;
            pact_ff <= 4'h0;
        end else begin
            cmd_ff <= nxt_cmd_ff;
            stop_hold_ff <= nxt_stop_hold_ff;
            off_cnt_ff <= nxt_off_cnt_ff;
            pact_ff <= pact;
        end
    end
    assign drive_cmd = cmd_ff;
    assign stat = {2'h0, off_live, stop_hold_ff, pact, tact, cmd_ff};

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_keb_blocks: assert property (drive_cmd.run |-> !$past(ctrl_ff[`RS_KEB_BIT])) // [R6]
        else $error("run while kinetic energy backup enabled");
    chk_fire_blocks: assert property (drive_cmd.run |-> !$past(fire_cfg)) // [R5]
        else $error("run while fire mode configured");
    chk_src_sched: assert property (drive_cmd.run |-> $past(ctrl_ff[`RS_SRC_LSB +: 3]) == `RS_SRC_SCHED) // [R7]
        else $error("run from non schedule source");
    chk_timer_gate: assert property (drive_cmd.run && $past(sel) != `RS_SEL_COMBO |-> $past(sel_tact)) // [R8]
        else $error("run without selected timer");
    chk_combo_stage: assert property (drive_cmd.run && $past(sel) == `RS_SEL_COMBO |-> drive_cmd.stage == $past(tact[1:0])) // [R4]
        else $error("combined stage mismatch");
    chk_single_stage: assert property (drive_cmd.run && $past(sel) != `RS_SEL_COMBO |-> drive_cmd.stage == 2'h0) // [R18]
        else $error("single timer stage not zero");
    chk_dir_lock: assert property (drive_cmd.run |-> !(drive_cmd.rev && $past(lock) == `RS_LOCK_NO_REV)) // [R3]
        else $error("locked reverse commanded");
    chk_fwd_default: assert property (drive_cmd.run && $past(dir) == 4'h0 |-> !drive_cmd.rev) // [R12]
        else $error("reverse with direction bits clear");
    chk_period_off: assert property (per_ff[0][16:0] == per_ff[1][16:0] |-> !pact[0]) // [R16]
        else $error("zero length period active");
    chk_stop_hold: assert property (stop_rise && cmd_ff.run |=> stop_hold_ff ##1 !drive_cmd.run) // [R10]
        else $error("STOP did not hold the drive");
    chk_offset_load: assert property (off_trig |=> off_cnt_ff == $past(off_load)) // [R9]
        else $error("offset time not loaded");
    chk_day_range: assert property (now_ff.day >= 3'h1 && now_ff.day <= `RS_DAY_LAST) // [R13]
        else $error("weekday out of range");
    cov_combo_run: cover property (drive_cmd.run && drive_cmd.stage == 2'h3);
    cov_offset_start: cover property (off_trig ##1 drive_cmd.run);
    cov_stop_resume: cover property (stop_hold_ff ##1 !stop_hold_ff);
endmodule : rtc_schedule_run_selector
`default_nettype wire

// ===== bench/drive_path_model.sv
`timescale 1ns/100ps
`default_nettype none
// Far side: terminal block and keypad of the drive; also watches the command it receives
module drive_path_model
    import rtc_sched_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire drive_cmd_s drive_cmd,
    input wire logic [5:0] di_req,
    input wire logic stop_req,
    output logic [5:0] di_pin,
    output logic stop_key,
    output int run_starts
);
    logic run_d;
    // Terminal levels move only after a rising edge, like a contact seen by the drive
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            di_pin <= 6'h00;
            stop_key <= 1'b0;
        end else begin
            di_pin <= di_req;
            stop_key <= stop_req;
        end
    end
    // Count run starts; the run and frequency path follows whatever it is given
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_d <= 1'b0;
            run_starts <= 0;
        end else begin
            run_d <= drive_cmd.run;
            if (drive_cmd.run && !run_d) begin
                run_starts <= run_starts + 1;
            end
        end
    end
endmodule : drive_path_model
`default_nettype wire

// ===== bench/rtc_schedule_run_selector_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtc_sched_defs.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module rtc_schedule_run_selector_test
    import rtc_sched_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [5:0] di_pin;
    logic [5:0] di_req = 6'h00;
    logic stop_key;
    logic stop_req = 1'b0;
    drive_cmd_s drive_cmd;
    int run_starts;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] q;

    // Short second of 8 cycles; the running clock still stays near its loaded value
    rtc_schedule_run_selector #(.TICK_CYC(8), .N_DI(6)) u_dut (.clk(clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .di_pin(di_pin), .stop_key(stop_key), .drive_cmd(drive_cmd));
    drive_path_model u_far (.clk(clk), .rst_b(rst_b), .drive_cmd(drive_cmd), .di_req(di_req),
        .stop_req(stop_req), .di_pin(di_pin), .stop_key(stop_key), .run_starts(run_starts));

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // One Avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] rdv);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= is_wr;
        avs_read <= !is_wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            $display("mismatch bus_answer expected 0 seen 1");
        end
        // Read data taken at the very edge that ends the wait
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask : rd

    // Command is a level; settle n cycles then look mid-cycle
    task automatic expect_cmd(input logic [3:0] e, input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
        `CHK("drive_cmd", e, drive_cmd)
    endtask : expect_cmd

    function automatic logic [31:0] ctrl(logic [2:0] spd, logic [3:0] dir, logic [2:0] src, logic [1:0] lock,
        logic kinetic_energy_backup, logic [1:0] offs);
        return {16'h0000, lock, src, dir, spd, kinetic_energy_backup, offs, 1'b1};
    endfunction : ctrl

    function automatic logic [31:0] tw(logic [2:0] day, logic [4:0] hr, logic [5:0] mn);
        return {12'h000, day, hr, mn, 6'h00};
    endfunction : tw

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(`RS_CTRL, q);
        `CHK("ctrl_reset", 32'h0000_0000, q)
        rd(`RS_TIME, q);
        `CHK("time_reset", 32'h0002_0000, q)
        rd(6'h3C, q);
        `CHK("unmapped", 32'h0000_0000, q)
        wr(`RS_TIME, tw(3'h1, 5'h08, 6'h00));
        wr(`RS_PER, tw(3'h1, 5'h06, 6'h00));
        wr(`RS_PER + 6'h04, tw(3'h1, 5'h16, 6'h00));
        wr(`RS_TSRC, 32'h0000_0001);
        wr(`RS_CTRL, ctrl(3'h1, 4'h0, `RS_SRC_SCHED, 2'h0, 1'b0, 2'h0));
        expect_cmd(4'h8, 2);
        for (int s = 0; s < 4; s++) begin
            wr(`RS_CTRL, ctrl(3'h1, 4'h0, 3'(s), 2'h0, 1'b0, 2'h0));
            expect_cmd(4'h0, 2);
        end
        wr(`RS_CTRL, ctrl(3'h1, 4'h1, `RS_SRC_SCHED, 2'h0, 1'b0, 2'h0));
        expect_cmd(4'hC, 2);
        wr(`RS_CTRL, ctrl(3'h1, 4'h1, `RS_SRC_SCHED, `RS_LOCK_NO_REV, 1'b0, 2'h0));
        expect_cmd(4'h4, 2);
        wr(`RS_CTRL, ctrl(3'h1, 4'h0, `RS_SRC_SCHED, `RS_LOCK_NO_FWD, 1'b0, 2'h0));
        expect_cmd(4'h0, 2);
        wr(`RS_CTRL, ctrl(3'h2, 4'h0, `RS_SRC_SCHED, 2'h0, 1'b0, 2'h0));
        expect_cmd(4'h0, 2);
        wr(`RS_CTRL, ctrl(3'h1, 4'h0, `RS_SRC_SCHED, 2'h0, 1'b1, 2'h0));
        expect_cmd(4'h0, 2);
        wr(`RS_CTRL, ctrl(3'h1, 4'h0, `RS_SRC_SCHED, 2'h0, 1'b0, 2'h0));
        wr(`RS_DIFN1, {24'h0, `RS_FIRE_CODE});
        expect_cmd(4'h0, 2);
        wr(`RS_DIFN1, 32'h0);
        wr(`RS_TSRC, 32'h0000_0008);
        expect_cmd(4'h0, 2);
        wr(`RS_TSRC, 32'h0000_000F);
        expect_cmd(4'h8, 2);
        // Weekday window: Tuesday to Friday seen from Monday, then from Wednesday
        wr(`RS_PER + 6'h08, tw(3'h2, 5'h06, 6'h00));
        wr(`RS_PER + 6'h0C, tw(3'h5, 5'h16, 6'h00));
        rd(`RS_PER + 6'h0C, q);
        `CHK("period_stop", tw(3'h5, 5'h16, 6'h00), q)
        wr(`RS_TSRC, 32'h0000_0002);
        expect_cmd(4'h0, 2);
        wr(`RS_TIME, tw(3'h3, 5'h08, 6'h00));
        expect_cmd(4'h8, 2);
        // Start equal to stop at the exact current second: still off
        wr(`RS_PER, tw(3'h1, 5'h08, 6'h00));
        wr(`RS_PER + 6'h04, tw(3'h1, 5'h08, 6'h00));
        wr(`RS_TIME, tw(3'h1, 5'h08, 6'h00));
        wr(`RS_TSRC, 32'h0000_0001);
        expect_cmd(4'h0, 1);
        wr(`RS_PER + 6'h04, tw(3'h1, 5'h16, 6'h00));
        // Combined mode: every timer pair, distinct direction bits
        for (int k = 0; k < 4; k++) begin
            wr(`RS_TSRC, {22'h0, 5'(k >> 1), 5'(k & 1)});
            wr(`RS_CTRL, ctrl(`RS_SEL_COMBO, 4'hA, `RS_SRC_SCHED, 2'h0, 1'b0, 2'h0));
            expect_cmd({1'b1, 4'hA >> k & 4'h1 ? 1'b1 : 1'b0, 2'(k)}, 2);
        end
        // Offset run started from a terminal with the offset function code
        wr(`RS_DIFN0, {16'h0, `RS_DI_OFFSET, 8'h00});
        wr(`RS_OFFS, 32'h0000_0001);
        wr(`RS_TSRC, 32'h0000_0010);
        wr(`RS_CTRL, ctrl(3'h1, 4'h0, `RS_SRC_SCHED, 2'h0, 1'b0, `RS_OFF_DI));
        expect_cmd(4'h0, 2);
        di_req <= 6'h02;
        expect_cmd(4'h8, 8);
        di_req <= 6'h00;
        wr(`RS_TSRC, 32'h0000_0011);
        expect_cmd(4'h8, 2);
        stop_req <= 1'b1;
        repeat (3) @(posedge clk);
        stop_req <= 1'b0;
        expect_cmd(4'h0, 8);
        expect_cmd(4'h0, 40);
        di_req <= 6'h02;
        expect_cmd(4'h8, 8);
        // Second STOP, status word during the hold, then a restart by writing the offset time
        stop_req <= 1'b1;
        repeat (3) @(posedge clk);
        stop_req <= 1'b0;
        expect_cmd(4'h0, 8);
        rd(`RS_STAT, q);
        `CHK("status_hold", 32'h0000_3110, q)
        wr(`RS_CTRL, ctrl(3'h1, 4'h0, `RS_SRC_SCHED, 2'h0, 1'b0, `RS_OFF_EN));
        expect_cmd(4'h0, 2);
        wr(`RS_OFFS, 32'h0000_0001);
        expect_cmd(4'h8, 2);
        `CHK("run_starts", 11, run_starts)
        final_report();
    end
endmodule : rtc_schedule_run_selector_test
`default_nettype wire
